// ---- verilog/dcs_pkg.sv ----
package dcs_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [2:0] DCS_OFS_CFG7 = 3'h0;
  localparam logic [2:0] DCS_OFS_CFG8 = 3'h1;
  localparam logic [2:0] DCS_OFS_CFG9 = 3'h2;
  localparam logic [2:0] DCS_OFS_CTRL = 3'h3;
  localparam logic [2:0] DCS_OFS_STAT = 3'h4;

  // ----------------------------------------
  // Field positions in configuration and status words
  // ----------------------------------------
  localparam int DCS_POS_DATA = 0;
  localparam int DCS_POS_CSEL = 8;
  localparam int DCS_POS_EDGE = 12;
  localparam int DCS_POS_FSEL = 14;
  localparam int DCS_POS_LOCK = 0;
  localparam int DCS_POS_ERR = 1;
  localparam int DCS_POS_OUT = 2;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [14:0] DCS_RST_CFG = 15'h0000;
  localparam logic [7:0] DCS_RST_CNT = 8'h00;

  // ----------------------------------------
  // Clock source codes
  // ----------------------------------------
  localparam logic [3:0] DCS_CK_RC = 4'h0;
  localparam logic [3:0] DCS_CK_D4 = 4'h1;
  localparam logic [3:0] DCS_CK_D12 = 4'h2;
  localparam logic [3:0] DCS_CK_D24 = 4'h3;
  localparam logic [3:0] DCS_CK_D64 = 4'h4;
  localparam logic [3:0] DCS_CK_CHAIN = 4'h5;
  localparam logic [3:0] DCS_CK_FAB = 4'h6;
  localparam logic [3:0] DCS_CK_F72D8 = 4'h7;
  localparam logic [3:0] DCS_CK_RING = 4'h8;
  localparam logic [3:0] DCS_CK_F83 = 4'h9;
  localparam logic [3:0] DCS_CK_LF = 4'hA;
  localparam logic [3:0] DCS_CK_SM256 = 4'hB;
  localparam logic [3:0] DCS_CK_MOD = 4'hC;
  localparam logic [3:0] DCS_CK_RSV = 4'hD;
  localparam logic [2:0] DCS_C7_RC = 3'h0;
  localparam logic [2:0] DCS_C7_D4 = 3'h1;
  localparam logic [2:0] DCS_C7_D24 = 3'h2;
  localparam logic [2:0] DCS_C7_D64 = 3'h3;
  localparam logic [2:0] DCS_C7_LF = 3'h4;
  localparam logic [2:0] DCS_C7_CHAIN = 3'h5;
  localparam logic [2:0] DCS_C7_RING = 3'h6;
  localparam logic [2:0] DCS_C7_F73 = 3'h7;

  // ----------------------------------------
  // Edge modes and functions
  // ----------------------------------------
  localparam logic [1:0] DCS_EDGE_BOTH = 2'h0;
  localparam logic [1:0] DCS_EDGE_FALL = 2'h1;
  localparam logic [1:0] DCS_EDGE_RISE = 2'h2;
  localparam logic [1:0] DCS_EDGE_NONE = 2'h3;
  localparam logic DCS_FN_DELAY = 1'b0;

  // Configuration of one stage
  typedef struct packed {
    logic fsel;
    logic [1:0] edge_mode;
    logic [3:0] clk_sel;
    logic [7:0] data;
  } dcs_cfg_type;

  // Clock and signal sources seen by the stages
  typedef struct packed {
    logic rc_oscillator;
    logic rc_div4;
    logic rc_div12;
    logic rc_div24;
    logic rc_div64;
    logic low_frequency_oscillator;
    logic ring_oscillator;
    logic fabric_b_signal_73;
    logic fabric_a_signal_72;
    logic fabric_a_signal_83;
    logic state_machine_clock_div256;
    logic modulator_clock;
    logic stage_six_output;
  } dcs_src_type;

endpackage

// ---- verilog/dcs_stages.sv ----
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module dcs_stages import dcs_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Source pins
  input wire dcs_src_type src,
  input wire logic [2:0] stage_in,
  // Register port
  input wire logic [2:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // Stage outputs (seven, eight, nine)
  output logic [2:0] stage_out
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    dcs_src_type src_m;         // First sync stage
    dcs_src_type src_s;         // Second sync stage
    logic [2:0] in_m;           // Stage input first sync
    logic [2:0] in_s;           // Stage input second sync
    logic [2:0] in_p;           // Previous stage input
    logic [2:0] ck_p;           // Previous selected clock
    logic f72_p;                // Previous fabric 72
    logic [2:0] div8;           // Fabric 72 divider
    dcs_cfg_type [2:0] cfg;     // Stage settings
    logic [2:0][7:0] cnt;       // Stage counters
    logic [2:0] run;            // Delay in progress
    logic [2:0] out;            // Stage outputs
    logic lock;                 // Settings frozen
    logic err;                  // Reserved code refused
    logic [31:0] rdata;         // Read answer
  } dcs_state_type;

  dcs_state_type st_q;
  dcs_state_type st_d;
  logic [2:0] ck_sel;           // Selected clock per stage
  logic [2:0] hit;              // Qualifying input edge
  logic [2:0] tick;             // Selected clock rising edge

  // Mux for the four-bit selectors of stages eight and nine
  function automatic logic ck_mux4(input dcs_src_type s, input logic [3:0] code,
                                   input logic chain, input logic fab, input logic d8);
    case (code)
      DCS_CK_RC: ck_mux4 = s.rc_oscillator;
      DCS_CK_D4: ck_mux4 = s.rc_div4;
      DCS_CK_D12: ck_mux4 = s.rc_div12;
      DCS_CK_D24: ck_mux4 = s.rc_div24;
      DCS_CK_D64: ck_mux4 = s.rc_div64;
      DCS_CK_CHAIN: ck_mux4 = chain;
      DCS_CK_FAB: ck_mux4 = fab;
      DCS_CK_F72D8: ck_mux4 = d8;
      DCS_CK_RING: ck_mux4 = s.ring_oscillator;
      DCS_CK_F83: ck_mux4 = s.fabric_a_signal_83;
      DCS_CK_LF: ck_mux4 = s.low_frequency_oscillator;
      DCS_CK_SM256: ck_mux4 = s.state_machine_clock_div256;
      DCS_CK_MOD: ck_mux4 = s.modulator_clock;
      default: ck_mux4 = 1'b0;
    endcase
  endfunction

  // Edge qualifier shared by delay and counter modes
  function automatic logic edge_hit(input logic [1:0] m, input logic r, input logic f);
    case (m)
      DCS_EDGE_BOTH: edge_hit = r | f;
      DCS_EDGE_FALL: edge_hit = f;
      DCS_EDGE_RISE: edge_hit = r;
      default: edge_hit = 1'b0;
    endcase
  endfunction

  // ----------------------------------------
  // Clock selection
  // ----------------------------------------
  always_comb begin
    // Stage seven three-bit selector
    case (st_q.cfg[0].clk_sel[2:0])
      DCS_C7_RC: ck_sel[0] = st_q.src_s.rc_oscillator;
      DCS_C7_D4: ck_sel[0] = st_q.src_s.rc_div4;
      DCS_C7_D24: ck_sel[0] = st_q.src_s.rc_div24;
      DCS_C7_D64: ck_sel[0] = st_q.src_s.rc_div64;
      DCS_C7_LF: ck_sel[0] = st_q.src_s.low_frequency_oscillator;
      DCS_C7_CHAIN: ck_sel[0] = st_q.src_s.stage_six_output;
      DCS_C7_RING: ck_sel[0] = st_q.src_s.ring_oscillator;
      default: ck_sel[0] = st_q.src_s.fabric_b_signal_73;
    endcase
    // Stage eight chains from seven, fabric b 73
    ck_sel[1] = ck_mux4(st_q.src_s, st_q.cfg[1].clk_sel, st_q.out[0],
                        st_q.src_s.fabric_b_signal_73, st_q.div8[2]);
    // Stage nine chains from eight, fabric a 72 undivided
    ck_sel[2] = ck_mux4(st_q.src_s, st_q.cfg[2].clk_sel, st_q.out[1],
                        st_q.src_s.fabric_a_signal_72, st_q.div8[2]);
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.src_m = src;
    st_d.src_s = st_q.src_m;
    st_d.in_m = stage_in;
    st_d.in_s = st_q.in_m;
    st_d.in_p = st_q.in_s;
    st_d.ck_p = ck_sel;
    st_d.f72_p = st_q.src_s.fabric_a_signal_72;
    st_d.rdata = 32'h0000_0000;
    // Divide fabric a 72 by eight on its rising edges
    if (st_q.src_s.fabric_a_signal_72 && !st_q.f72_p) begin
      st_d.div8 = st_q.div8 + 3'h1;
    end
    // Stage engines
    for (int i = 0; i < 3; i++) begin
      tick[i] = ck_sel[i] & ~st_q.ck_p[i];
      hit[i] = edge_hit(st_q.cfg[i].edge_mode, st_q.in_s[i] & ~st_q.in_p[i],
                        ~st_q.in_s[i] & st_q.in_p[i]);
      if (st_q.cfg[i].fsel == DCS_FN_DELAY) begin
        // Delay: qualifying edge loads count, output follows input at expiry
        if (hit[i]) begin
          st_d.run[i] = 1'b1;
          st_d.cnt[i] = st_q.cfg[i].data;
        end else if (st_q.run[i] && tick[i]) begin
          if (st_q.cnt[i] == DCS_RST_CNT) begin
            st_d.run[i] = 1'b0;
            st_d.out[i] = st_q.in_s[i];
          end else begin
            st_d.cnt[i] = st_q.cnt[i] - 8'h01;
          end
        end
      end else begin
        // Counter: reset condition reloads, expiry gives one tick pulse
        st_d.run[i] = 1'b0;
        if ((st_q.cfg[i].edge_mode == DCS_EDGE_NONE) ? st_q.in_s[i] : hit[i]) begin
          st_d.cnt[i] = st_q.cfg[i].data;
          st_d.out[i] = 1'b0;
        end else if (tick[i]) begin
          if (st_q.cnt[i] == DCS_RST_CNT) begin
            st_d.cnt[i] = st_q.cfg[i].data;
            st_d.out[i] = 1'b1;
          end else begin
            st_d.cnt[i] = st_q.cnt[i] - 8'h01;
            st_d.out[i] = 1'b0;
          end
        end
      end
    end
    // Register writes
    if (wr) begin
      if (addr <= DCS_OFS_CFG9 && !st_q.lock) begin
        if (addr != DCS_OFS_CFG7 && wdata[DCS_POS_CSEL+:4] >= DCS_CK_RSV) begin
          st_d.err = 1'b1;
        end else begin
          st_d.cfg[addr[1:0]] = wdata[14:0];
          if (addr == DCS_OFS_CFG7) begin
            st_d.cfg[0].clk_sel[3] = 1'b0;
          end
        end
      end else if (addr == DCS_OFS_CTRL && wdata[DCS_POS_LOCK]) begin
        st_d.lock = 1'b1;
      end
    end
    // Register reads, answered next cycle
    if (rd) begin
      case (addr)
        DCS_OFS_CFG7, DCS_OFS_CFG8, DCS_OFS_CFG9: st_d.rdata = {17'h0, st_q.cfg[addr[1:0]]};
        DCS_OFS_CTRL: st_d.rdata = {31'h0, st_q.lock};
        DCS_OFS_STAT: st_d.rdata = {27'h0, st_q.out, st_q.err, st_q.lock};
        default: st_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata = st_q.rdata;
  assign stage_out = st_q.out;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_c7_fab;
    @(posedge clk) disable iff (!rst_n)
      st_q.cfg[0].clk_sel[2:0] == DCS_C7_F73 |-> ck_sel[0] == st_q.src_s.fabric_b_signal_73;
  endproperty
  a_c7_fab: assert property (p_c7_fab) else $error("stage seven code 7 wrong");

  property p_c8_chain;
    @(posedge clk) disable iff (!rst_n)
      st_q.cfg[1].clk_sel == DCS_CK_CHAIN |-> ck_sel[1] == st_q.out[0];
  endproperty
  a_c8_chain: assert property (p_c8_chain) else $error("stage eight chain wrong");

  property p_c9_fab;
    @(posedge clk) disable iff (!rst_n)
      st_q.cfg[2].clk_sel == DCS_CK_FAB |-> ck_sel[2] == st_q.src_s.fabric_a_signal_72;
  endproperty
  a_c9_fab: assert property (p_c9_fab) else $error("stage nine code 6 wrong");

  property p_delay_none;
    @(posedge clk) disable iff (!rst_n)
      st_q.cfg[0].fsel == DCS_FN_DELAY &&
      st_q.cfg[0].edge_mode == DCS_EDGE_NONE && !st_q.run[0] |=> !st_q.run[0];
  endproperty
  a_delay_none: assert property (p_delay_none) else $error("delay started with no edge");

  property p_cnt_level;
    @(posedge clk) disable iff (!rst_n)
      st_q.cfg[1].fsel && st_q.cfg[1].edge_mode == DCS_EDGE_NONE &&
      st_q.in_s[1] |=> st_q.cnt[1] == $past(st_q.cfg[1].data) && !st_q.out[1];
  endproperty
  a_cnt_level: assert property (p_cnt_level) else $error("level reset not held");

  property p_delay_start;
    @(posedge clk) disable iff (!rst_n)
      st_q.cfg[0].fsel == DCS_FN_DELAY && hit[0] |=> st_q.run[0];
  endproperty
  a_delay_start: assert property (p_delay_start) else $error("delay did not start");

  property p_load8;
    @(posedge clk) disable iff (!rst_n)
      hit[1] |=> st_q.cnt[1] == $past(st_q.cfg[1].data);
  endproperty
  a_load8: assert property (p_load8) else $error("stage eight count not loaded");

  property p_frozen;
    @(posedge clk) disable iff (!rst_n)
      st_q.lock |=> st_q.lock && $stable(st_q.cfg);
  endproperty
  a_frozen: assert property (p_frozen) else $error("settings changed after lock");

  property p_reserved;
    @(posedge clk) disable iff (!rst_n)
      wr && addr == DCS_OFS_CFG8 && !st_q.lock && wdata[11:8] >= DCS_CK_RSV
      |=> st_q.err && $stable(st_q.cfg);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved code accepted");

  // ----------------------------------------
  // Behaviour checks
  // ----------------------------------------
  // Stage seven never holds a four-bit clock code
  property p_c7_msb;
    @(posedge clk) disable iff (!rst_n)
      !st_q.cfg[0].clk_sel[3];
  endproperty
  a_c7_msb: assert property (p_c7_msb) else $error("stage seven code too wide");

  // Reserved clock codes can never be stored
  property p_rsv_silent;
    @(posedge clk) disable iff (!rst_n)
      st_q.cfg[1].clk_sel < DCS_CK_RSV && st_q.cfg[2].clk_sel < DCS_CK_RSV;
  endproperty
  a_rsv_silent: assert property (p_rsv_silent) else $error("reserved code stored");

  // Stage seven loads its count on a qualifying edge
  property p_load7;
    @(posedge clk) disable iff (!rst_n)
      hit[0] |=> st_q.cnt[0] == $past(st_q.cfg[0].data);
  endproperty
  a_load7: assert property (p_load7) else $error("stage seven count not loaded");

  // Delay expiry hands the input level to the output
  property p_delay_expire;
    @(posedge clk) disable iff (!rst_n)
      st_q.cfg[0].fsel == DCS_FN_DELAY && st_q.run[0] && tick[0] && !hit[0] &&
      st_q.cnt[0] == DCS_RST_CNT |=> !st_q.run[0] && st_q.out[0] == $past(st_q.in_s[0]);
  endproperty
  a_delay_expire: assert property (p_delay_expire) else $error("delay expiry wrong");

  // Counter wrap reloads the count and raises the output
  property p_cnt_wrap;
    @(posedge clk) disable iff (!rst_n)
      st_q.cfg[2].fsel && tick[2] && st_q.cnt[2] == DCS_RST_CNT && !hit[2] &&
      !(st_q.cfg[2].edge_mode == DCS_EDGE_NONE && st_q.in_s[2])
      |=> st_q.out[2] && st_q.cnt[2] == $past(st_q.cfg[2].data);
  endproperty
  a_cnt_wrap: assert property (p_cnt_wrap) else $error("counter wrap wrong");

  // The refusal flag stays set until reset
  property p_err_sticky;
    @(posedge clk) disable iff (!rst_n)
      st_q.err |=> st_q.err;
  endproperty
  a_err_sticky: assert property (p_err_sticky) else $error("refusal flag cleared");

  // Read answer stands one cycle only, zero otherwise
  property p_rd_idle;
    @(posedge clk) disable iff (!rst_n)
      !rd |=> st_q.rdata == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read answer outside its cycle");

endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import dcs_pkg::*;

  // ----------------------------------------
  // Clock, stimulus and counters
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  dcs_src_type src = '0;
  logic [2:0] stage_in = 3'h0;
  logic [2:0] addr = 3'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [2:0] stage_out;
  logic [31:0] v;
  logic got;
  logic [1:0] rc_div = 2'h0;
  int n_fail = 0;
  int compares = 0;

  // Free-running 100 ns clock
  always #50 clk = ~clk;

  // Slow oscillator source: toggles every four clocks
  always @(posedge clk) begin
    rc_div <= rc_div + 2'h1;
    if (rc_div == 2'h1) begin
      src.rc_oscillator <= ~src.rc_oscillator;
    end
  end

  // Device under test
  dcs_stages u_dut (
    .clk(clk), .rst_n(rst_n), .src(src), .stage_in(stage_in), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .stage_out(stage_out)
  );

  // ----------------------------------------
  // Bus tasks and comparison
  // ----------------------------------------
  // Compare a seen value with the expected one
  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One-cycle write strobe
  task bus_wr(input logic [2:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // One-cycle read strobe, data taken in the following cycle
  task bus_rd(input logic [2:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask

  // Configuration word: function, edge mode, clock code, data
  function automatic logic [31:0] cw(input logic f, input logic [1:0] e,
                                     input logic [3:0] c, input logic [7:0] d);
    cw = {17'h0, f, e, c, d};
  endfunction

  // Wait a bounded number of cycles for a stage output level
  task wait_bit(input int b, input logic lvl, input int lim);
    got = 1'b0;
    for (int i = 0; i < lim && !got; i++) begin
      @(negedge clk);
      if (stage_out[b] === lvl) got = 1'b1;
    end
  endtask

  // Verdict and end of run
  task results();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Watchdog against a hung wait
  initial begin
    #(20000 * 100);
    n_fail++;
    results();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    // Power-on configuration is all zero
    for (int a = 0; a < 5; a++) begin
      bus_rd(a[2:0], v);
      check(v, 32'h0);
    end
    // Every legal code of stages eight and nine, with fields
    for (int c = 0; c < 13; c++) begin
      bus_wr(DCS_OFS_CFG8, cw(c[0], c[1:0], c[3:0], 8'hA5 ^ c[7:0]));
      bus_rd(DCS_OFS_CFG8, v);
      check(v, cw(c[0], c[1:0], c[3:0], 8'hA5 ^ c[7:0]));
      bus_wr(DCS_OFS_CFG9, cw(~c[0], c[1:0], c[3:0], c[7:0]));
      bus_rd(DCS_OFS_CFG9, v);
      check(v, cw(~c[0], c[1:0], c[3:0], c[7:0]));
    end
    bus_rd(DCS_OFS_STAT, v);
    check(v & 32'h3, 32'h0);
    // Reserved codes are refused and flagged
    for (int c = 13; c < 16; c++) begin
      bus_wr(DCS_OFS_CFG8, cw(1'b0, 2'h0, c[3:0], 8'h11));
      bus_rd(DCS_OFS_CFG8, v);
      check(v, cw(1'b0, 2'h0, 4'hC, 8'h0C ^ 8'hA5));
    end
    bus_rd(DCS_OFS_STAT, v);
    check(v & 32'h3, 32'h2);
    // Stage seven: three-bit selector, top bit dropped
    for (int c = 0; c < 8; c++) begin
      bus_wr(DCS_OFS_CFG7, cw(c[0], DCS_EDGE_NONE, {1'b1, c[2:0]}, 8'hFF));
      bus_rd(DCS_OFS_CFG7, v);
      check(v, cw(c[0], DCS_EDGE_NONE, {1'b0, c[2:0]}, 8'hFF));
    end
    // Unmapped place reads zero
    bus_wr(3'h6, 32'hFFFF_FFFF);
    bus_rd(3'h6, v);
    check(v, 32'h0);
    // Stage seven delay, rising edge only, two counts on the RC source
    bus_wr(DCS_OFS_CFG7, cw(DCS_FN_DELAY, DCS_EDGE_RISE, DCS_CK_RC, 8'h02));
    bus_wr(DCS_OFS_CFG8, cw(DCS_FN_DELAY, DCS_EDGE_NONE, DCS_CK_RC, 8'h01));
    bus_wr(DCS_OFS_CFG9, cw(1'b1, DCS_EDGE_FALL, DCS_CK_RC, 8'h01));
    @(posedge clk);
    stage_in <= 3'h3;
    repeat (5) @(negedge clk);
    check({31'h0, stage_out[0]}, 32'h0);
    wait_bit(0, 1'b1, 80);
    check({31'h0, got}, 32'h1);
    // Edge mode none never fires on stage eight
    check({31'h0, stage_out[1]}, 32'h0);
    // Falling edge is ignored by the rising-only delay
    @(posedge clk);
    stage_in <= 3'h0;
    wait_bit(0, 1'b0, 60);
    check({31'h0, got}, 32'h0);
    check({31'h0, stage_out[1]}, 32'h0);
    // Stage nine as a counter: output pulses and returns low
    wait_bit(2, 1'b1, 80);
    check({31'h0, got}, 32'h1);
    wait_bit(2, 1'b0, 80);
    check({31'h0, got}, 32'h1);
    // Stage eight counter held in reset while its input stays high
    @(posedge clk);
    stage_in <= 3'h2;
    bus_wr(DCS_OFS_CFG8, cw(1'b1, DCS_EDGE_NONE, DCS_CK_RC, 8'h01));
    wait_bit(1, 1'b1, 40);
    check({31'h0, got}, 32'h0);
    @(posedge clk);
    stage_in <= 3'h0;
    wait_bit(1, 1'b1, 40);
    check({31'h0, got}, 32'h1);
    // Count of zero keeps the output high once it wraps
    bus_wr(DCS_OFS_CFG8, cw(1'b1, DCS_EDGE_FALL, DCS_CK_RC, 8'h00));
    wait_bit(1, 1'b0, 20);
    check({31'h0, got}, 32'h1);
    wait_bit(1, 1'b1, 20);
    check({31'h0, got}, 32'h1);
    // Stopped clock: a rising edge leaves it, a falling edge clears it
    bus_wr(DCS_OFS_CFG8, cw(1'b1, DCS_EDGE_FALL, DCS_CK_MOD, 8'h00));
    @(posedge clk);
    stage_in <= 3'h2;
    wait_bit(1, 1'b0, 10);
    check({31'h0, got}, 32'h0);
    @(posedge clk);
    stage_in <= 3'h0;
    wait_bit(1, 1'b0, 10);
    check({31'h0, got}, 32'h1);
    // Lock freezes the configuration
    bus_wr(DCS_OFS_CTRL, 32'h1);
    bus_rd(DCS_OFS_STAT, v);
    check(v & 32'h3, 32'h3);
    @(negedge clk);
    check(rdata, 32'h0);
    bus_wr(DCS_OFS_CFG7, cw(1'b1, 2'h3, 4'h7, 8'h55));
    bus_rd(DCS_OFS_CFG7, v);
    check(v, cw(DCS_FN_DELAY, DCS_EDGE_RISE, DCS_CK_RC, 8'h02));
    results();
  end
endmodule
`default_nettype wire
